//--- src/rmcc_top.v
// configuration command interpreter for the radio module
// assumes bytes arrive as one-cycle strobes from a uart on the same clock,
// and config_sel is a raw pin, synchronised here
// How it works
// RULE_01: a command byte is matched as a binary value, so ascii and binary forms are the same.
// RULE_02: the host sends every argument as a raw binary byte.
// RULE_03: 0x43 with an argument 0x01-0x53 sets the volatile channel.
// RULE_04: 0x50 with an argument 0x01-0x05 sets the volatile power level.
// RULE_05: 0x53 answers one byte of signal strength; the code sends no reply while an earlier reply byte still waits untaken.
// RULE_06: 0x54 with any argument sets the volatile destination address.
// RULE_07: 0x4d enters memory editing of address-data pairs, left by address 0xff.
// RULE_08: 0x58 leaves configuration and applies all changed parameters; the code re-enters configuration one cycle later while config select is held.
// RULE_09: 0x5a sleeps while config select is held, and its release wakes.
// RULE_10: 0x30 outputs a listing of memory parameters and identification.
// RULE_11: 0x31 transmits an unmodulated carrier until idle is chosen.
// RULE_12: 0x32 transmits a pn9 modulated carrier until idle is chosen.
// RULE_13: 0x33 enters raw receive until idle is chosen.
// RULE_14: 0x34 selects idle with receiver and transmitter off.
// RULE_15: 0x35 powers the radio down until a power-up command.
// RULE_16: 0x36 powers the radio up, needed before radio tests after power down.
// RULE_17: an unknown command byte is ignored and the next byte is awaited.
`timescale 1ns/1ps
`default_nettype none
`include "rmcc_defines.vh"
module rmcc_top #(
   parameter [7:0] PRODUCT_ID = 8'h5a, // arbitrary value
   parameter [7:0] REVISION_ID = 8'h01 // arbitrary value
) (
   input wire clk,
   input wire nrst,
   input wire config_sel_n,
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire tx_ready,
   output wire tx_valid,
   output wire [7:0] tx_data,
   input wire [7:0] rssi_level,
   output wire nv_wr,
   output wire [7:0] nv_addr,
   output wire [7:0] nv_wdata,
   output wire [7:0] nv_rd_addr,
   input wire [7:0] nv_rdata,
   output wire in_config,
   output wire sleep,
   output wire [7:0] channel,
   output wire [7:0] power_level,
   output wire [7:0] dest_addr,
   output wire apply,
   output wire [2:0] test_mode,
   output wire radio_pd,
   output wire tx_on,
   output wire rx_on,
   output wire pn9_bit
);
   localparam [2:0] ST_NORMAL = 3'h0;
   localparam [2:0] ST_CMD = 3'h1;
   localparam [2:0] ST_ARG = 3'h2;
   localparam [2:0] ST_MADDR = 3'h3;
   localparam [2:0] ST_MDATA = 3'h4;
   localparam [2:0] ST_SLEEP = 3'h5;
   localparam [2:0] ST_LIST = 3'h6;
   reg sel_meta_reg, sel_sync_reg, pd_reg, pd_next, apply_reg, apply_next;
   reg nvwr_reg, nvwr_next, txv_reg, txv_next;
   reg [2:0] state_reg, state_next, tm_reg, tm_next;
   reg [7:0] arg_cmd_reg, arg_cmd_next, chan_reg, chan_next, pwr_reg, pwr_next;
   reg [7:0] dest_reg, dest_next, maddr_reg, maddr_next, nvwd_reg, nvwd_next;
   reg [7:0] txd_reg, txd_next;
   reg [`RMCC_LIST_W-1:0] lidx_reg, lidx_next;
   wire sel_active, tx_free, pn9_run;
   // config select pin through two flops
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sel_meta_reg <= 1'b0;
         sel_sync_reg <= 1'b0;
      end else begin
         sel_meta_reg <= ~config_sel_n;
         sel_sync_reg <= sel_meta_reg;
      end
   end
   assign sel_active = sel_sync_reg;
   assign tx_free = ~txv_reg | tx_ready;
   // state and parameter registers
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_NORMAL;
         arg_cmd_reg <= 8'h00;
         chan_reg <= `RMCC_CHAN_RST;
         pwr_reg <= `RMCC_PWR_RST;
         dest_reg <= `RMCC_DEST_RST;
         maddr_reg <= 8'h00;
         tm_reg <= `RMCC_TM_IDLE;
         pd_reg <= 1'b0;
         apply_reg <= 1'b0;
         nvwr_reg <= 1'b0;
         nvwd_reg <= 8'h00;
         txv_reg <= 1'b0;
         txd_reg <= 8'h00;
         lidx_reg <= {`RMCC_LIST_W{1'b0}};
      end else begin
         state_reg <= state_next;
         arg_cmd_reg <= arg_cmd_next;
         chan_reg <= chan_next;
         pwr_reg <= pwr_next;
         dest_reg <= dest_next;
         maddr_reg <= maddr_next;
         tm_reg <= tm_next;
         pd_reg <= pd_next;
         apply_reg <= apply_next;
         nvwr_reg <= nvwr_next;
         nvwd_reg <= nvwd_next;
         txv_reg <= txv_next;
         txd_reg <= txd_next;
         lidx_reg <= lidx_next;
      end
   end
   // command decoding and sequencing
   always @* begin
      state_next = state_reg;
      arg_cmd_next = arg_cmd_reg;
      chan_next = chan_reg;
      pwr_next = pwr_reg;
      dest_next = dest_reg;
      maddr_next = maddr_reg;
      tm_next = tm_reg;
      pd_next = pd_reg;
      apply_next = 1'b0;
      nvwr_next = 1'b0;
      nvwd_next = nvwd_reg;
      txv_next = txv_reg & ~tx_ready;
      txd_next = txd_reg;
      lidx_next = lidx_reg;
      case (state_reg)
         ST_NORMAL: begin
            if (sel_active) begin
               state_next = ST_CMD;
            end
         end
         ST_CMD: begin
            if (!sel_active) begin
               state_next = ST_NORMAL; // select released without exit
            end else if (rx_valid) begin
               // RULE_01 binary match
               case (rx_data)
                  `RMCC_CMD_CHANNEL, `RMCC_CMD_POWER, `RMCC_CMD_DEST: begin
                     arg_cmd_next = rx_data;
                     state_next = ST_ARG;
                  end
                  `RMCC_CMD_RSSI: begin
                     // RULE_05 rssi reply
                     if (tx_free) begin
                        txv_next = 1'b1;
                        txd_next = rssi_level;
                     end
                  end
                  `RMCC_CMD_MEMCFG: begin
                     // RULE_07 enter editing
                     state_next = ST_MADDR;
                  end
                  `RMCC_CMD_EXIT: begin
                     // RULE_08 apply and leave
                     apply_next = 1'b1;
                     state_next = ST_NORMAL;
                  end
                  `RMCC_CMD_SLEEP: begin
                     // RULE_09 enter sleep
                     state_next = ST_SLEEP;
                  end
                  `RMCC_CMD_TEST0: begin
                     // RULE_10 start listing
                     lidx_next = {`RMCC_LIST_W{1'b0}};
                     state_next = ST_LIST;
                  end
                  `RMCC_CMD_CARRIER: begin
                     // RULE_11 carrier test
                     if (!pd_reg) tm_next = `RMCC_TM_CARRIER;
                  end
                  `RMCC_CMD_PN9: begin
                     // RULE_12 pn9 test
                     if (!pd_reg) tm_next = `RMCC_TM_PN9;
                  end
                  `RMCC_CMD_RAWRX: begin
                     // RULE_13 raw receive
                     if (!pd_reg) tm_next = `RMCC_TM_RAWRX;
                  end
                  `RMCC_CMD_IDLE: begin
                     // RULE_14 radio idle
                     tm_next = `RMCC_TM_IDLE;
                  end
                  `RMCC_CMD_PWRDN: begin
                     // RULE_15 power down
                     pd_next = 1'b1;
                     tm_next = `RMCC_TM_IDLE;
                  end
                  `RMCC_CMD_PWRUP: begin
                     // RULE_16 power up
                     pd_next = 1'b0;
                  end
                  default: begin
                     // RULE_17 ignore unknown
                     state_next = ST_CMD;
                  end
               endcase
            end
         end
         ST_ARG: begin
            if (!sel_active) begin
               state_next = ST_NORMAL;
            end else if (rx_valid) begin
               state_next = ST_CMD;
               // RULE_03 channel range
               if (arg_cmd_reg == `RMCC_CMD_CHANNEL && rx_data >= `RMCC_CHAN_MIN &&
                     rx_data <= `RMCC_CHAN_MAX)
                  chan_next = rx_data;
               // RULE_04 power range
               if (arg_cmd_reg == `RMCC_CMD_POWER && rx_data >= `RMCC_PWR_MIN &&
                     rx_data <= `RMCC_PWR_MAX)
                  pwr_next = rx_data;
               // RULE_06 destination any
               if (arg_cmd_reg == `RMCC_CMD_DEST) dest_next = rx_data;
            end
         end
         ST_MADDR: begin
            // RULE_07 address or exit
            if (!sel_active) begin
               state_next = ST_NORMAL;
            end else if (rx_valid) begin
               if (rx_data == `RMCC_MEM_EXIT) begin
                  state_next = ST_CMD;
               end else begin
                  maddr_next = rx_data;
                  state_next = ST_MDATA;
               end
            end
         end
         ST_MDATA: begin
            // RULE_07 write pair
            if (!sel_active) begin
               state_next = ST_NORMAL;
            end else if (rx_valid) begin
               nvwr_next = 1'b1;
               nvwd_next = rx_data;
               state_next = ST_MADDR;
            end
         end
         ST_SLEEP: begin
            // RULE_09 release wakes
            if (!sel_active) begin
               state_next = ST_NORMAL;
            end
         end
         ST_LIST: begin
            // RULE_10 id, revision, then memory bytes
            if (tx_free) begin
               txv_next = 1'b1;
               if (lidx_reg == {`RMCC_LIST_W{1'b0}}) begin
                  txd_next = PRODUCT_ID;
               end else if (lidx_reg == {{(`RMCC_LIST_W-1){1'b0}}, 1'b1}) begin
                  txd_next = REVISION_ID;
               end else begin
                  txd_next = nv_rdata;
               end
               lidx_next = lidx_reg + {{(`RMCC_LIST_W-1){1'b0}}, 1'b1};
               if (lidx_reg == `RMCC_LIST_LEN - 6'h01) begin
                  state_next = ST_CMD;
               end
            end
         end
         default: begin
            state_next = ST_NORMAL;
         end
      endcase
   end
   // pn9 source for modulated test
   assign pn9_run = (tm_reg == `RMCC_TM_PN9);
   rmcc_pn9 i_rmcc_pn9 (
      .clk(clk),
      .nrst(nrst),
      .run(pn9_run),
      .bit_out(pn9_bit)
   );
   assign tx_valid = txv_reg;
   assign tx_data = txd_reg;
   assign nv_wr = nvwr_reg;
   assign nv_addr = maddr_reg;
   assign nv_wdata = nvwd_reg;
   // listing reads memory from address 0 after two id bytes
   assign nv_rd_addr = {2'b00, lidx_reg - 6'h02};
   assign in_config = (state_reg != ST_NORMAL);
   assign sleep = (state_reg == ST_SLEEP);
   assign channel = chan_reg;
   assign power_level = pwr_reg;
   assign dest_addr = dest_reg;
   assign apply = apply_reg;
   assign test_mode = pd_reg ? `RMCC_TM_PWRDN : tm_reg;
   assign radio_pd = pd_reg;
   assign tx_on = (tm_reg == `RMCC_TM_CARRIER) || (tm_reg == `RMCC_TM_PN9);
   assign rx_on = (tm_reg == `RMCC_TM_RAWRX);
endmodule
`default_nettype wire

//--- shared/rmcc_defines.vh
// command codes, parameter resets and limits for the config interpreter
// assumes inclusion by bare name from design files
`ifndef RMCC_DEFINES_VH
`define RMCC_DEFINES_VH
// command bytes
`define RMCC_CMD_CHANNEL 8'h43
`define RMCC_CMD_POWER 8'h50
`define RMCC_CMD_RSSI 8'h53
`define RMCC_CMD_DEST 8'h54
`define RMCC_CMD_MEMCFG 8'h4d
`define RMCC_CMD_EXIT 8'h58
`define RMCC_CMD_SLEEP 8'h5a
`define RMCC_CMD_TEST0 8'h30
`define RMCC_CMD_CARRIER 8'h31
`define RMCC_CMD_PN9 8'h32
`define RMCC_CMD_RAWRX 8'h33
`define RMCC_CMD_IDLE 8'h34
`define RMCC_CMD_PWRDN 8'h35
`define RMCC_CMD_PWRUP 8'h36
`define RMCC_MEM_EXIT 8'hff
// argument ranges
`define RMCC_CHAN_MIN 8'h01
`define RMCC_CHAN_MAX 8'h53
`define RMCC_PWR_MIN 8'h01
`define RMCC_PWR_MAX 8'h05
// volatile reset values
`define RMCC_CHAN_RST 8'h32
`define RMCC_PWR_RST 8'h05
`define RMCC_DEST_RST 8'h00
// test modes on test_mode output
`define RMCC_TM_IDLE 3'h0
`define RMCC_TM_CARRIER 3'h1
`define RMCC_TM_PN9 3'h2
`define RMCC_TM_RAWRX 3'h3
`define RMCC_TM_PWRDN 3'h4
// parameter listing length in bytes (arbitrary id bytes included)
`define RMCC_LIST_LEN 6'h3c
`define RMCC_LIST_W 6
`endif

//--- src/rmcc_pn9.v
// pn9 pseudo-random generator for modulated transmit test
// assumes clk and nrst of the interpreter
`timescale 1ns/1ps
`default_nettype none
module rmcc_pn9 (
   input wire clk,
   input wire nrst,
   input wire run,
   output wire bit_out
);
   reg [8:0] lfsr_reg;
   // x^9 + x^5 + 1, reseeded while stopped
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lfsr_reg <= 9'h1ff;
      end else if (run) begin
         lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
      end else begin
         lfsr_reg <= 9'h1ff;
      end
   end
   assign bit_out = lfsr_reg[8];
endmodule
`default_nettype wire

//--- dv/rmcc_assertions.sv
// checker on the config interpreter ports
// assumes one clock and an async active-low reset, bound onto rmcc_top
`timescale 1ns/1ps
`default_nettype none
`include "rmcc_defines.vh"
module rmcc_assertions (
   input wire clk,
   input wire nrst,
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire tx_ready,
   input wire tx_valid,
   input wire [7:0] tx_data,
   input wire nv_wr,
   input wire [7:0] nv_addr,
   input wire [7:0] channel,
   input wire [7:0] power_level,
   input wire apply,
   input wire [2:0] test_mode,
   input wire radio_pd,
   input wire tx_on,
   input wire rx_on
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_chan_range: assert property (channel >= 8'h01 && channel <= 8'h53)
      else $error("channel outside its range");
   chk_power_range: assert property (power_level >= 8'h01 && power_level <= 8'h05)
      else $error("power level outside its range");
   chk_apply_cause: assert property (apply |-> $past(rx_valid) && $past(rx_data) == 8'h58)
      else $error("apply without exit byte");
   chk_reply_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply byte dropped before taken");
   chk_nv_pair: assert property (nv_wr |-> nv_addr != 8'hff ##1 !nv_wr)
      else $error("bad memory write");
   chk_idle_off: assert property (test_mode == `RMCC_TM_IDLE |-> !tx_on && !rx_on)
      else $error("radio active in idle");
   chk_tx_modes: assert property (test_mode == 3'h1 || test_mode == 3'h2 |-> tx_on && !rx_on)
      else $error("transmit test not transmitting");
   chk_pd_quiet: assert property (radio_pd |-> test_mode == 3'h4 && !tx_on && !rx_on)
      else $error("powered down yet active");
endmodule
bind rmcc_top rmcc_assertions i_rmcc_assertions (.clk(clk), .nrst(nrst), .rx_valid(rx_valid),
   .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
   .nv_wr(nv_wr), .nv_addr(nv_addr), .channel(channel), .power_level(power_level),
   .apply(apply), .test_mode(test_mode), .radio_pd(radio_pd), .tx_on(tx_on), .rx_on(rx_on));
`default_nettype wire

//--- dv/rmcc_host.sv
// host model on the serial config link: sends bytes, takes reply bytes
// assumes the interpreter clock; drives on falling edges
`timescale 1ns/1ps
`default_nettype none
module rmcc_host (
   input wire clk,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic tx_ready,
   input wire tx_valid,
   input wire [7:0] tx_data
);
   int slow = 0; // stall cycles before each reply is taken
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
   task send(input logic [7:0] b);
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = b;
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~b; // no stale byte on the idle line
   endtask
   // take one reply after a stall, bounded wait
   task recv(output logic [7:0] b, output logic ok);
      int n;
      ok = 1'b0;
      b = 8'h00;
      repeat (slow + 1) @(negedge clk); // at least one edge passes with ready low between replies
      tx_ready = 1'b1;
      for (n = 0; n < 200 && !ok; n++) begin
         @(posedge clk);
         if (tx_valid === 1'b1) begin
            ok = 1'b1;
            b = tx_data;
         end
      end
      @(negedge clk);
      tx_ready = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- dv/rmcc_top_test.sv
// self-checking bench for the config interpreter
// assumes rmcc_host on the link and nv reads returning the inverted address
`timescale 1ns/1ps
`default_nettype none
`include "rmcc_defines.vh"
module rmcc_top_test;
   localparam logic [7:0] PID = 8'ha7; // arbitrary value
   localparam logic [7:0] RID = 8'h3e; // arbitrary value
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic config_sel_n = 1'b1;
   logic [7:0] rssi_level = 8'h00;
   wire rx_valid, tx_ready, tx_valid, nv_wr, in_config, sleep, apply, radio_pd, tx_on, rx_on;
   wire pn9_bit;
   wire [7:0] rx_data, tx_data, nv_addr, nv_wdata, nv_rd_addr, channel, power_level, dest_addr;
   wire [2:0] test_mode;
   wire [7:0] nv_rdata = ~nv_rd_addr; // combinational nv image
   int num_errors = 0;
   int checked = 0;
   int k;
   logic [7:0] nv_a = 8'h00;
   logic [7:0] nv_d = 8'h00;
   logic [7:0] b;
   logic [19:0] pn;
   logic saw_apply = 1'b0;
   always #50 clk = ~clk;
   // capture memory writes and apply pulses
   always @(posedge clk) begin
      if (nv_wr === 1'b1) begin
         nv_a <= nv_addr;
         nv_d <= nv_wdata;
      end
      if (apply === 1'b1) saw_apply <= 1'b1;
   end
   rmcc_top #(.PRODUCT_ID(PID), .REVISION_ID(RID)) i_rmcc_top (.clk(clk), .nrst(nrst),
      .config_sel_n(config_sel_n), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .rssi_level(rssi_level), .nv_wr(nv_wr),
      .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rd_addr(nv_rd_addr), .nv_rdata(nv_rdata),
      .in_config(in_config), .sleep(sleep), .channel(channel), .power_level(power_level),
      .dest_addr(dest_addr), .apply(apply), .test_mode(test_mode), .radio_pd(radio_pd),
      .tx_on(tx_on), .rx_on(rx_on), .pn9_bit(pn9_bit));
   rmcc_host i_rmcc_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
      .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task cmd(input logic [7:0] c);
      i_rmcc_host.send(c);
      @(negedge clk);
   endtask
   task cmd2(input logic [7:0] c, input logic [7:0] a);
      i_rmcc_host.send(c);
      cmd(a);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task get(output logic [7:0] r);
      logic ok;
      i_rmcc_host.recv(r, ok);
      if (!ok) begin
         num_errors++;
         $display("ERROR reply expected 01 seen 00");
         end_sim();
      end
   endtask
   initial begin
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      config_sel_n = 1'b0;
      repeat (4) @(negedge clk);
      cmd2("C", 8'h53);
      chk("channel", 8'h53, channel);
      cmd2(`RMCC_CMD_CHANNEL, 8'h54);
      chk("channel", 8'h53, channel);
      cmd2("P", 8'h01);
      chk("power", 8'h01, power_level);
      cmd2(`RMCC_CMD_POWER, 8'h06);
      chk("power", 8'h01, power_level);
      cmd2("T", 8'hff);
      chk("dest", 8'hff, dest_addr);
      cmd(8'h41);
      cmd2("C", 8'h01);
      chk("channel", 8'h01, channel);
      $display("volatile settings done");
      rssi_level = 8'h7b;
      i_rmcc_host.slow = 3;
      cmd("S");
      get(b);
      chk("rssi", 8'h7b, b);
      cmd("M");
      cmd2(8'h05, 8'ha5);
      chk("nv addr", 8'h05, nv_a);
      chk("nv data", 8'ha5, nv_d);
      cmd(`RMCC_MEM_EXIT);
      cmd2("C", 8'h20);
      chk("channel", 8'h20, channel);
      $display("rssi and memory done");
      for (k = 0; k < 4; k++) begin
         cmd(8'h31 + k[7:0]);
         chk("mode", (k == 3) ? 8'h00 : k[7:0] + 8'h01, {5'h00, test_mode});
         chk("rf", (k == 3) ? 8'h00 : (k == 2) ? 8'h01 : 8'h02, {6'h00, tx_on, rx_on});
      end
      cmd(`RMCC_CMD_PWRDN);
      chk("pd", 8'h01, {7'h00, radio_pd});
      cmd(`RMCC_CMD_CARRIER);
      chk("mode", 8'h04, {5'h00, test_mode});
      cmd(`RMCC_CMD_PWRUP);
      chk("pd", 8'h00, {7'h00, radio_pd});
      cmd(`RMCC_CMD_CARRIER);
      chk("mode", 8'h01, {5'h00, test_mode});
      cmd(`RMCC_CMD_IDLE);
      cmd(`RMCC_CMD_PN9);
      for (k = 0; k < 20; k++) begin
         @(negedge clk);
         pn[k] = pn9_bit;
      end
      // each bit is the xor of the bits nine and five places earlier
      for (k = 9; k < 20; k++) begin
         chk("pn9", {7'h00, pn[k - 9] ^ pn[k - 5]}, {7'h00, pn[k]});
      end
      chk("pn9 ones", 8'h01, {7'h00, |pn});
      cmd(`RMCC_CMD_IDLE);
      $display("test modes done");
      i_rmcc_host.slow = 0;
      cmd("0");
      for (k = 0; k < `RMCC_LIST_LEN; k++) begin
         get(b);
         chk("list", (k == 0) ? PID : (k == 1) ? RID : ~(k[7:0] - 8'h02), b);
      end
      cmd("X");
      chk("apply", 8'h01, {7'h00, saw_apply});
      chk("channel", 8'h20, channel);
      config_sel_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("in config", 8'h00, {7'h00, in_config});
      $display("listing and exit done");
      config_sel_n = 1'b0;
      repeat (4) @(negedge clk);
      cmd("Z");
      chk("sleep", 8'h01, {7'h00, sleep});
      cmd2("C", 8'h10);
      chk("channel", 8'h20, channel);
      config_sel_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("sleep", 8'h00, {7'h00, sleep});
      $display("sleep done");
      end_sim();
   end
endmodule
`default_nettype wire
